// ==== rtl/dma_channel_mode_control.sv ====
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module dma_channel_mode_control #(
    parameter int NUM_CH  = dma_pkg::NUM_CH,
    parameter int NUM_EXT = dma_pkg::NUM_EXT
) (
    input  wire logic                       CLK,
    input  wire logic                       RST_B,
    input  wire logic                       PSEL,
    input  wire logic                       PENABLE,
    input  wire logic                       PWRITE,
    input  wire logic [dma_pkg::OFS_W-1:0]  PADDR,
    input  wire logic [31:0]                PWDATA,
    output logic [31:0]                     PRDATA,
    output logic                            PREADY,
    output logic                            PSLVERR,
    input  wire logic [NUM_EXT-1:0]         EXT_REQUEST_IN,
    output logic [NUM_EXT-1:0]              EXT_ACKNOWLEDGE_OUT,
    output logic [NUM_EXT-1:0]              TRANSFER_END_OUT,
    output logic                            XFER_VALID,
    output logic                            XFER_WRITE,
    output logic [31:0]                     XFER_ADDR
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad_ch
        $error("NUM_CH must be 1 to 4 to fit the register map");
    end
    if (NUM_EXT < 1 || NUM_EXT > NUM_CH) begin : g_bad_ext
        $error("NUM_EXT must be 1 to NUM_CH");
    end

    localparam int CH_W = 2;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE,
        ST_SINGLE
    } state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel registers
    logic [31:0]               src_q  [NUM_CH];
    logic [31:0]               dst_q  [NUM_CH];
    logic [dma_pkg::CNT_W-1:0] cnt_q  [NUM_CH];
    logic [31:0]               ctrl_q [NUM_CH];
    logic [NUM_CH-1:0]         wr_en;
    logic [NUM_CH-1:0]         unit_done;
    logic                      last_unit;
    logic                      bus_write;
    logic                      in_map;
    logic [CH_W-1:0]           addr_ch;
    logic [1:0]                addr_idx;

    assign in_map    = PADDR < dma_pkg::MAP_TOP;
    assign addr_ch   = PADDR[dma_pkg::CH_LSB +: CH_W];
    assign addr_idx  = PADDR[dma_pkg::WORD_LSB +: 2];
    assign bus_write = PSEL && PENABLE && PWRITE && in_map && (int'(addr_ch) < NUM_CH);

    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        assign wr_en[g] = bus_write && (int'(addr_ch) == g);
        dma_chan_regs #(
            .HAS_EXT   (g < NUM_EXT)
        ) u_regs (
            .clk       (CLK),
            .rst_n     (rst_n),
            .wr_en     (wr_en[g]),
            .wr_idx    (addr_idx),
            .wdata     (PWDATA),
            .unit_done (unit_done[g]),
            .last_unit (last_unit),
            .src_q     (src_q[g]),
            .dst_q     (dst_q[g]),
            .cnt_q     (cnt_q[g]),
            .ctrl_q    (ctrl_q[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: read data is captured in the setup cycle, so no wait states
    logic [31:0] rd_word;
    logic        addr_ok;

    assign addr_ok = in_map && (int'(addr_ch) < NUM_CH);

    always_comb begin
        rd_word = 32'h00000000;
        if (addr_ok) begin
            unique case (addr_idx)
                dma_pkg::IDX_SRC:  rd_word = src_q[addr_ch];
                dma_pkg::IDX_DST:  rd_word = dst_q[addr_ch];
                dma_pkg::IDX_CNT:  rd_word = {{(32-dma_pkg::CNT_W){1'b0}}, cnt_q[addr_ch]};
                dma_pkg::IDX_CTRL: rd_word = ctrl_q[addr_ch];
            endcase
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            PRDATA <= 32'h00000000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= rd_word;
        end
    end

    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !addr_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Request pick-up; overrun 0 ignores requests seen while a unit runs
    logic [NUM_CH-1:0] pend_q;
    logic [NUM_CH-1:0] want;
    logic [NUM_CH-1:0] start;
    state_t            state_q;
    logic [CH_W-1:0]   act_q;

    function automatic logic is_ext(input logic [31:0] c);
        logic [3:0] rs;
        rs = c[dma_pkg::RS_HI:dma_pkg::RS_LO];
        is_ext = (rs == dma_pkg::RS_EXT_DUAL) || (rs == dma_pkg::RS_SINGLE_TO_DEV) ||
                 (rs == dma_pkg::RS_SINGLE_FROM_DEV);
    endfunction

    function automatic logic is_single(input logic [31:0] c);
        logic [3:0] rs;
        rs = c[dma_pkg::RS_HI:dma_pkg::RS_LO];
        is_single = (rs == dma_pkg::RS_SINGLE_TO_DEV) || (rs == dma_pkg::RS_SINGLE_FROM_DEV);
    endfunction

    for (genvar g = 0; g < NUM_CH; g++) begin : g_req
        if (g < NUM_EXT) begin : g_ext
            always_ff @(posedge CLK or negedge rst_n) begin
                if (!rst_n) begin
                    pend_q[g] <= 1'b0;
                end else if (EXT_REQUEST_IN[g] &&
                             (state_q == ST_IDLE || ctrl_q[g][dma_pkg::BIT_OVERRUN])) begin
                    pend_q[g] <= 1'b1;
                end else if (start[g] || !ctrl_q[g][dma_pkg::BIT_EN]) begin
                    pend_q[g] <= 1'b0;
                end
            end
            assign want[g] = ctrl_q[g][dma_pkg::BIT_EN] &&
                             (is_ext(ctrl_q[g]) ? pend_q[g] :
                              ctrl_q[g][dma_pkg::RS_HI:dma_pkg::RS_LO] == dma_pkg::RS_AUTO);
        end else begin : g_int
            assign pend_q[g] = 1'b0;
            assign want[g]   = ctrl_q[g][dma_pkg::BIT_EN] &&
                               ctrl_q[g][dma_pkg::RS_HI:dma_pkg::RS_LO] == dma_pkg::RS_AUTO;
        end
    end

    // Fixed priority, lowest channel first
    logic [CH_W-1:0] pick;
    logic            any_want;

    always_comb begin
        pick     = '0;
        any_want = 1'b0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (want[i]) begin
                pick     = CH_W'(i);
                any_want = 1'b1;
            end
        end
    end

    for (genvar g = 0; g < NUM_CH; g++) begin : g_start
        assign start[g]     = (state_q == ST_IDLE) && any_want && (int'(pick) == g);
        assign unit_done[g] = (int'(act_q) == g) && (state_q == ST_WRITE || state_q == ST_SINGLE);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Unit sequencer: dual mode reads then writes, single mode is one cycle
    logic [31:0] act_ctrl;

    assign act_ctrl  = ctrl_q[act_q];
    assign last_unit = cnt_q[act_q] == dma_pkg::CNT_ONE;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (any_want) begin
                        state_q <= (int'(pick) < NUM_EXT && is_single(ctrl_q[pick])) ? ST_SINGLE : ST_READ;
                    end
                end
                ST_READ:   state_q <= ST_WRITE;
                ST_WRITE:  state_q <= ST_IDLE;
                ST_SINGLE: state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            act_q <= '0;
        end else if (state_q == ST_IDLE && any_want) begin
            act_q <= pick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycle toward memory
    logic        cyc_valid;
    logic        cyc_write;
    logic [31:0] cyc_addr;

    always_comb begin
        cyc_valid = 1'b0;
        cyc_write = 1'b0;
        cyc_addr  = 32'h00000000;
        unique case (state_q)
            ST_IDLE: begin
                cyc_valid = 1'b0;
            end
            ST_READ: begin
                cyc_valid = 1'b1;
                cyc_addr  = src_q[act_q];
            end
            ST_WRITE: begin
                cyc_valid = 1'b1;
                cyc_write = 1'b1;
                cyc_addr  = dst_q[act_q];
            end
            ST_SINGLE: begin
                // Memory side only; the device side is addressed by acknowledge
                cyc_valid = 1'b1;
                if (act_ctrl[dma_pkg::RS_HI:dma_pkg::RS_LO] == dma_pkg::RS_SINGLE_TO_DEV) begin
                    cyc_addr = src_q[act_q];
                end else begin
                    cyc_write = 1'b1;
                    cyc_addr  = dst_q[act_q];
                end
            end
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            XFER_VALID <= 1'b0;
            XFER_WRITE <= 1'b0;
            XFER_ADDR  <= 32'h00000000;
        end else begin
            XFER_VALID <= cyc_valid;
            XFER_WRITE <= cyc_write;
            XFER_ADDR  <= cyc_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Handshake pins, registered so they line up with the bus cycle outputs.
    // Polarity changes take effect one clock after the control write, even when idle, so the pin rests inactive.
    for (genvar g = 0; g < NUM_EXT; g++) begin : g_pin
        logic mine;
        logic ack_on;
        logic end_on;

        assign mine   = (int'(act_q) == g) && is_ext(ctrl_q[g]);
        assign ack_on = mine && ((state_q == ST_SINGLE) ||
                                 (state_q == ST_READ  && !ctrl_q[g][dma_pkg::BIT_ACK_TIM]) ||
                                 (state_q == ST_WRITE &&  ctrl_q[g][dma_pkg::BIT_ACK_TIM]));
        assign end_on = (int'(act_q) == g) && last_unit && (state_q == ST_WRITE || state_q == ST_SINGLE);

        always_ff @(posedge CLK or negedge rst_n) begin
            if (!rst_n) begin
                EXT_ACKNOWLEDGE_OUT[g] <= 1'b1;
                TRANSFER_END_OUT[g]    <= 1'b1;
            end else begin
                EXT_ACKNOWLEDGE_OUT[g] <= ack_on ~^ ctrl_q[g][dma_pkg::BIT_ACK_POL];
                TRANSFER_END_OUT[g]    <= end_on ~^ ctrl_q[g][dma_pkg::BIT_END_POL];
            end
        end
    end

endmodule

// ==== rtl/dma_pkg.sv ====
package dma_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Geometry
    localparam int NUM_CH     = 4;
    localparam int NUM_EXT    = 2;
    localparam int CNT_W      = 24;
    localparam int OFS_W      = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Register map: one block of four words per channel
    localparam logic [1:0]       IDX_SRC    = 2'h0;
    localparam logic [1:0]       IDX_DST    = 2'h1;
    localparam logic [1:0]       IDX_CNT    = 2'h2;
    localparam logic [1:0]       IDX_CTRL   = 2'h3;
    localparam int               WORD_LSB   = 2;
    localparam int               CH_LSB     = 4;
    localparam logic [OFS_W-1:0] MAP_TOP    = 8'h40;

    ////////////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int BIT_OVERRUN  = 23;
    localparam int BIT_END_POL  = 22;
    localparam int BIT_ACK_TIM  = 17;
    localparam int BIT_ACK_POL  = 16;
    localparam int DM_HI        = 15;
    localparam int DM_LO        = 14;
    localparam int SM_HI        = 13;
    localparam int SM_LO        = 12;
    localparam int RS_HI        = 11;
    localparam int RS_LO        = 8;
    localparam int SZ_HI        = 4;
    localparam int SZ_LO        = 3;
    localparam int BIT_DONE     = 1;
    localparam int BIT_EN       = 0;

    localparam logic [31:0] CTRL_MASK_EXT = 32'h00C3FF1B;
    localparam logic [31:0] CTRL_MASK_INT = 32'h0000FF1B;
    localparam logic [31:0] CTRL_RESET    = 32'h00000000;
    localparam logic [31:0] ADDR_RESET    = 32'h00000000;
    localparam logic [CNT_W-1:0] CNT_RESET = 24'h000000;
    localparam logic [CNT_W-1:0] CNT_ONE   = 24'h000001;

    ////////////////////////////////////////////////////////////////////////////
    // Encodings
    localparam logic [1:0] ADDR_FIXED = 2'h0;
    localparam logic [1:0] ADDR_INC   = 2'h1;
    localparam logic [1:0] ADDR_DEC   = 2'h2;

    localparam logic [3:0] RS_EXT_DUAL      = 4'h0;
    localparam logic [3:0] RS_SINGLE_TO_DEV = 4'h2;
    localparam logic [3:0] RS_SINGLE_FROM_DEV = 4'h3;
    localparam logic [3:0] RS_AUTO          = 4'h4;

    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    localparam logic [1:0] SZ_16B  = 2'h3;

    localparam logic [31:0] STEP_BYTE = 32'h00000001;
    localparam logic [31:0] STEP_WORD = 32'h00000002;
    localparam logic [31:0] STEP_LONG = 32'h00000004;
    localparam logic [31:0] STEP_16B  = 32'h00000010;

endpackage

// ==== rtl/dma_chan_regs.sv ====
`timescale 1ns/1ps
module dma_chan_regs #(
    parameter bit HAS_EXT = 1'b1
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       wr_en,
    input  wire logic [1:0]                 wr_idx,
    input  wire logic [31:0]                wdata,
    input  wire logic                       unit_done,
    input  wire logic                       last_unit,
    output logic [31:0]                     src_q,
    output logic [31:0]                     dst_q,
    output logic [dma_pkg::CNT_W-1:0]       cnt_q,
    output logic [31:0]                     ctrl_q
);

    localparam logic [31:0] MASK = HAS_EXT ? dma_pkg::CTRL_MASK_EXT : dma_pkg::CTRL_MASK_INT;

    logic [1:0] size;
    logic [3:0] rsel;
    logic       skip_src;
    logic       skip_dst;

    assign size     = ctrl_q[dma_pkg::SZ_HI:dma_pkg::SZ_LO];
    assign rsel     = ctrl_q[dma_pkg::RS_HI:dma_pkg::RS_LO];
    assign skip_src = HAS_EXT && (rsel == dma_pkg::RS_SINGLE_FROM_DEV);
    assign skip_dst = HAS_EXT && (rsel == dma_pkg::RS_SINGLE_TO_DEV);

    // Step by unit size; mode 11 is treated as fixed, so a prohibited code cannot run away
    function automatic logic [31:0] next_addr(input logic [31:0] a, input logic [1:0] mode, input logic [1:0] sz);
        logic [31:0] step;
        step = dma_pkg::STEP_BYTE;
        unique case (sz)
            dma_pkg::SZ_BYTE: step = dma_pkg::STEP_BYTE;
            dma_pkg::SZ_WORD: step = dma_pkg::STEP_WORD;
            dma_pkg::SZ_LONG: step = dma_pkg::STEP_LONG;
            dma_pkg::SZ_16B:  step = dma_pkg::STEP_16B;
        endcase
        if (mode == dma_pkg::ADDR_INC) begin
            next_addr = a + step;
        end else if (mode == dma_pkg::ADDR_DEC) begin
            next_addr = a - step;
        end else begin
            next_addr = a;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Address registers always hold the next address to use
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            src_q <= dma_pkg::ADDR_RESET;
        end else if (unit_done && !skip_src) begin
            src_q <= next_addr(src_q, ctrl_q[dma_pkg::SM_HI:dma_pkg::SM_LO], size);
        end else if (wr_en && wr_idx == dma_pkg::IDX_SRC) begin
            src_q <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dst_q <= dma_pkg::ADDR_RESET;
        end else if (unit_done && !skip_dst) begin
            dst_q <= next_addr(dst_q, ctrl_q[dma_pkg::DM_HI:dma_pkg::DM_LO], size);
        end else if (wr_en && wr_idx == dma_pkg::IDX_DST) begin
            dst_q <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= dma_pkg::CNT_RESET;
        end else if (unit_done) begin
            cnt_q <= cnt_q - dma_pkg::CNT_ONE;
        end else if (wr_en && wr_idx == dma_pkg::IDX_CNT) begin
            cnt_q <= wdata[dma_pkg::CNT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control: reserved bits never store; done is set by hardware over a clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= dma_pkg::CTRL_RESET;
        end else begin
            if (wr_en && wr_idx == dma_pkg::IDX_CTRL) begin
                ctrl_q <= wdata & MASK;
            end
            if (unit_done && last_unit) begin
                ctrl_q[dma_pkg::BIT_DONE] <= 1'b1;
                ctrl_q[dma_pkg::BIT_EN]   <= 1'b0;
            end
        end
    end

endmodule

// ==== verif/dma_mode_chk.sv ====
`timescale 1ns/1ps
module dma_mode_chk #(
    parameter int NUM_EXT = dma_pkg::NUM_EXT
) (
    input wire logic                      CLK,
    input wire logic                      RST_B,
    input wire logic                      PSEL,
    input wire logic                      PENABLE,
    input wire logic                      PWRITE,
    input wire logic [dma_pkg::OFS_W-1:0] PADDR,
    input wire logic [31:0]               PWDATA,
    input wire logic [31:0]               PRDATA,
    input wire logic [NUM_EXT-1:0]        EXT_ACKNOWLEDGE_OUT,
    input wire logic [NUM_EXT-1:0]        TRANSFER_END_OUT,
    input wire logic                      XFER_VALID,
    input wire logic                      XFER_WRITE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    logic [31:0] c0_q;
    logic [31:0] c1_q;
    // Shadow copies of the pin controls; a cycle right after a change is skipped since the pins are registered
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            c0_q <= 32'h00000000;
            c1_q <= 32'h00000000;
        end else if (PSEL && PENABLE && PWRITE) begin
            if (PADDR == 8'h0C) c0_q <= PWDATA;
            if (PADDR == 8'h1C) c1_q <= PWDATA;
        end
    end
    a_rsvd_read_zero: assert property (PSEL && !PENABLE && !PWRITE && PADDR[3:0] == 4'hC
        |=> PRDATA[31:24] == 8'h00 && PRDATA[21:18] == 4'h0) else $error("reserved control bits not zero");
    a_int_pins_zero: assert property (PSEL && !PENABLE && !PWRITE && PADDR[7:4] inside {4'h2, 4'h3} &&
        PADDR[3:0] == 4'hC |=> PRDATA[23:22] == 2'h0 && PRDATA[17:16] == 2'h0) else $error("pin bits not zero");
    a_ack0_idle_lvl: assert property (!XFER_VALID && $stable(c0_q) |-> EXT_ACKNOWLEDGE_OUT[0] == !c0_q[16])
        else $error("ack 0 not inactive");
    a_ack1_idle_lvl: assert property (!XFER_VALID && $stable(c1_q) |-> EXT_ACKNOWLEDGE_OUT[1] == !c1_q[16])
        else $error("ack 1 not inactive");
    a_end0_idle_lvl: assert property (!XFER_VALID && $stable(c0_q) |-> TRANSFER_END_OUT[0] == !c0_q[22])
        else $error("end 0 not inactive");
    a_end1_idle_lvl: assert property (!XFER_VALID && $stable(c1_q) |-> TRANSFER_END_OUT[1] == !c1_q[22])
        else $error("end 1 not inactive");
    a_ack0_cycle_kind: assert property (XFER_VALID && c0_q[11:8] == 4'h0 && $stable(c0_q) &&
        EXT_ACKNOWLEDGE_OUT[0] == c0_q[16] |-> XFER_WRITE == c0_q[17]) else $error("ack 0 in wrong cycle");
    a_ack1_cycle_kind: assert property (XFER_VALID && c1_q[11:8] == 4'h0 && $stable(c1_q) &&
        EXT_ACKNOWLEDGE_OUT[1] == c1_q[16] |-> XFER_WRITE == c1_q[17]) else $error("ack 1 in wrong cycle");
endmodule
bind dma_channel_mode_control dma_mode_chk #(.NUM_EXT(NUM_EXT)) u_chk (
    .CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .EXT_ACKNOWLEDGE_OUT(EXT_ACKNOWLEDGE_OUT),
    .TRANSFER_END_OUT(TRANSFER_END_OUT), .XFER_VALID(XFER_VALID), .XFER_WRITE(XFER_WRITE));

// ==== verif/ext_requester.sv ====
`timescale 1ns/1ps
module ext_requester (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] want,
    input  wire logic       slow,
    input  wire logic       ack,
    input  wire logic       ack_lvl,
    output logic            req
);
    logic [3:0] done_q;
    logic [1:0] gap_q;
    logic       req_q;
    assign req = req_q;
    // Holds the request until acknowledged; stops after its data runs out so no stale request lingers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_q  <= 1'b0;
            done_q <= 4'h0;
            gap_q  <= 2'h0;
        end else if (want == 4'h0) begin
            req_q  <= 1'b0;
            done_q <= 4'h0;
        end else if (req_q && ack == ack_lvl) begin
            req_q  <= 1'b0;
            done_q <= done_q + 4'h1;
            gap_q  <= slow ? 2'h3 : 2'h0;
        end else if (gap_q != 2'h0) begin
            gap_q <= gap_q - 2'h1;
        end else begin
            req_q <= done_q < want;
        end
    end
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  ack;
    logic [1:0]  transfer_end_out;
    logic [1:0]  preq;
    logic        xv;
    logic        xw;
    logic [31:0] xa;
    logic [3:0]  want [2] = '{4'h0, 4'h0};
    logic [1:0]  alvl = 2'h0;
    logic        elvl = 1'b0;
    logic        pulse = 1'b0;
    logic [34:0] xe;
    logic [34:0] expq [$];
    int          fail_count = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          seed = 15662;
    int          cur = 0;
    always #2.5 clk = ~clk;
    dma_channel_mode_control DUT (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .EXT_REQUEST_IN(preq | {1'b0, pulse}), .EXT_ACKNOWLEDGE_OUT(ack), .TRANSFER_END_OUT(transfer_end_out),
        .XFER_VALID(xv), .XFER_WRITE(xw), .XFER_ADDR(xa));
    ext_requester u_dev0 (.clk(clk), .rst_n(rst_b), .want(want[0]), .slow(1'b0), .ack(ack[0]), .ack_lvl(alvl[0]),
        .req(preq[0]));
    ext_requester u_dev1 (.clk(clk), .rst_n(rst_b), .want(want[1]), .slow(1'b1), .ack(ack[1]), .ack_lvl(alvl[1]),
        .req(preq[1]));
    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) fail_count++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h00000000, r, e);
        chk(nm, x, r);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Reference model: every memory cycle must match the next queued expectation
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            print_verdict();
        end else if (rst_b && xv === 1'b1) begin
            if (expq.size() == 0) chk("xfer_extra", 32'h0, 32'h1);
            else begin
                xe = expq.pop_front();
                chk("xfer_addr", xe[31:0], xa);
                chk("xfer_write", {31'h0, xe[32]}, {31'h0, xw});
                chk("xfer_ack", {31'h0, xe[33]}, {31'h0, cur < 2 && (ack[cur] ~^ alvl[cur])});
                chk("xfer_end", {31'h0, xe[34]}, {31'h0, cur < 2 && (transfer_end_out[cur] ~^ elvl)});
            end
        end
    end
    task automatic run_ch(input int ch, rs, sz, sm, dm, tim, apol, epol, ovr, cnt, n, input logic [31:0] s, d);
        logic [31:0] ctl;
        logic [31:0] st;
        logic [31:0] ds;
        logic [31:0] dd;
        logic [7:0]  b;
        int          k;
        b = 8'(ch * 16);
        st = (sz == 3) ? 32'h10 : (32'h1 << sz);
        ds = (sm == 1) ? st : ((sm == 2) ? -st : 32'h0);
        dd = (dm == 1) ? st : ((dm == 2) ? -st : 32'h0);
        ctl = (ovr << 23) | (epol << 22) | (tim << 17) | (apol << 16) | (dm << 14) | (sm << 12);
        ctl = ctl | (rs << 8) | (sz << 3) | 1;
        cur <= ch;
        alvl[ch] <= apol[0];
        elvl <= epol[0];
        wr(b, s);
        wr(b + 8'h4, d);
        wr(b + 8'h8, cnt);
        for (k = 0; k < n; k++) begin
            if (rs == 0 || rs == 4) begin
                expq.push_back({1'b0, rs == 0 && tim == 0, 1'b0, s});
                expq.push_back({k == cnt - 1 && ch < 2, rs == 0 && tim == 1, 1'b1, d});
            end else expq.push_back({k == cnt - 1, 1'b1, rs == 3, (rs == 3) ? d : s});
            s = (rs == 3) ? s : s + ds;
            d = (rs == 2) ? d : d + dd;
        end
        wr(b + 8'hC, ctl);
        // Second pulse lands while the first unit is on the bus
        if (cnt > n) begin
            pulse <= 1'b1;
            @(posedge clk);
            pulse <= 1'b0;
            repeat (2) @(posedge clk);
            pulse <= 1'b1;
            @(posedge clk);
            pulse <= 1'b0;
        end else want[ch] <= 4'(n);
        k = 0;
        while (expq.size() != 0 && k < 300) begin
            @(posedge clk);
            k++;
        end
        repeat (20) @(posedge clk);
        chk("xfer_left", 32'h0, expq.size());
        want[ch] <= 4'h0;
        rd_chk("src", b, s);
        rd_chk("dst", b + 8'h4, d);
        rd_chk("ctl", b + 8'hC, (ctl & ~32'h1) | ((cnt > n) ? 32'h1 : 32'h2));
        wr(b + 8'hC, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        logic [31:0] w;
        logic        e;
        int          c;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        for (c = 0; c < 4; c++) begin
            rd_chk("ctl_reset", 8'(c * 16 + 12), dma_pkg::CTRL_RESET);
            w = ($random(seed) | 32'h00C30000) & 32'hFFFFFFFC;
            wr(8'(c * 16 + 12), w);
            rd_chk("ctl_mask", 8'(c * 16 + 12), w & (c < 2 ? dma_pkg::CTRL_MASK_EXT : dma_pkg::CTRL_MASK_INT));
            wr(8'(c * 16 + 12), 32'h0);
        end
        apb(1'b0, 8'h40, 32'h0, r, e);
        chk("unmapped_rd", 32'h0, r);
        chk("unmapped_err", 32'h1, {31'h0, e});
        run_ch(0, 0, 2, 1, 2, 0, 1, 1, 0, 3, 3, $random(seed) & 32'hFFFFFFFC, 32'h20000100);
        run_ch(1, 0, 1, 2, 0, 1, 0, 0, 0, 2, 2, 32'h00000800, 32'h00003000);
        run_ch(1, 2, 0, 0, 2, 1, 1, 1, 0, 2, 2, $random(seed), 32'h00004000);
        run_ch(0, 3, 3, 1, 1, 0, 0, 1, 0, 2, 2, 32'h00005000, $random(seed) & 32'hFFFFFFF0);
        run_ch(0, 0, 0, 1, 1, 0, 0, 0, 0, 4, 1, 32'h00006000, 32'h00007000);
        run_ch(0, 0, 0, 1, 1, 0, 0, 0, 1, 4, 2, 32'h00006000, 32'h00007000);
        run_ch(2, 4, 2, 1, 1, 0, 0, 0, 0, 2, 2, 32'h00008000, 32'h00009000);
        print_verdict();
    end
endmodule
